// *** hw/uart_irq_pkg.sv ***
// Constants shared by the serial channel interrupt logic.
// Assumes one system clock and a parallel register bus with a three-bit address.
package uart_irq_pkg;

    // Register addresses on the three-bit channel bus.
    localparam logic [2:0] ADDR_RX_BUFFER = 3'h0;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] ADDR_IRQ_IDENT = 3'h2;
    localparam logic [2:0] ADDR_FIFO_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;

    // Interrupt enable fields.
    localparam int IER_RX_DATA_BIT = 0;
    localparam int IER_TX_EMPTY_BIT = 1;
    localparam int IER_LINE_STATUS_BIT = 2;
    localparam int IER_MODEM_BIT = 3;
    localparam logic [7:0] IER_WRITE_MASK = 8'h0F;
    localparam logic [7:0] IER_RESET = 8'h00;

    // Fifo control fields.
    localparam int FCR_ENABLE_BIT = 0;
    localparam int FCR_TRIGGER_LSB = 6;
    localparam logic [1:0] TRIGGER_RESET = 2'h0;

    // Receive trigger levels, indexed by the two trigger bits.
    localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
    localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
    localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
    localparam logic [4:0] TRIG_LEVEL_3 = 5'h0E;

    // Identification codes in bits 3..0 of the identification register.
    localparam logic [3:0] IDENT_NONE = 4'h1;
    localparam logic [3:0] IDENT_LINE_STATUS = 4'h6;
    localparam logic [3:0] IDENT_RX_DATA = 4'h4;
    localparam logic [3:0] IDENT_TIMEOUT = 4'hC;
    localparam logic [3:0] IDENT_TX_EMPTY = 4'h2;
    localparam logic [3:0] IDENT_MODEM = 4'h0;

    // Character timing, in ticks of the sixteen-times baud clock.
    localparam int TICK_W = 10;
    localparam logic [TICK_W-1:0] TICKS_PER_BIT = 10'h010;
    localparam logic [TICK_W-1:0] TIMEOUT_CHARS = 10'h004;
    localparam logic [TICK_W-1:0] TICKS_TIMEOUT_PER_BIT = TICKS_PER_BIT * TIMEOUT_CHARS;
    localparam logic [1:0] TX_SHORT_BYTES = 2'h2;

endpackage : uart_irq_pkg

// *** hw/irq_sticky_flag.sv ***
// A single sticky event flag.
// Assumes set and clear are one-cycle terms from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module irq_sticky_flag (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_flag
);

    // A set in the clearing cycle wins, so no event is lost to a read.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end

endmodule // irq_sticky_flag
`default_nettype wire

// *** hw/irq_tick_timer.sv ***
// Counts baud ticks up to a limit and reports when it is reached.
// Assumes the tick is a one-cycle enable pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module irq_tick_timer #(
    parameter int W = 10
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_restart,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [W-1:0] i_limit,
    output logic o_done
);

    logic [W-1:0] count_r;

    // The count saturates at the limit so done stays up until a restart.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_r <= '0;
        end else if (i_restart) begin
            count_r <= '0;
        end else if (i_run && i_tick && count_r < i_limit) begin
            count_r <= count_r + 1'b1;
        end
    end

    assign o_done = i_run && !i_restart && (count_r >= i_limit);

endmodule // irq_tick_timer
`default_nettype wire

// *** hw/uart_irq_ctrl.sv ***
// Interrupt prioritisation and identification for one serial channel.
// Assumes the receiver, transmitter and baud generator run on i_clk and hand over
// one-cycle event pulses, fifo fill counts and a sixteen-times baud tick.
`timescale 1ns/1ps
`default_nettype none
module uart_irq_ctrl
    import uart_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_divisor_access,
    input wire logic i_baud16_tick,
    input wire logic [3:0] i_char_bits,
    input wire logic i_rx_push,
    input wire logic [4:0] i_rx_count,
    input wire logic [4:0] i_tx_count,
    input wire logic i_overrun_error,
    input wire logic i_parity_error,
    input wire logic i_framing_error,
    input wire logic i_break_indication,
    input wire logic i_modem_change,
    output logic [7:0] o_rdata,
    output logic o_channel_irq_out,
    output logic o_rx_data_ready_flag,
    output logic o_tx_holding_empty,
    output logic o_fifo_enable_bit,
    output logic [1:0] o_rx_trigger_sel
);

    logic [7:0] irq_enable_reg_r;
    logic [7:0] rdata_nxt;
    logic [7:0] irq_ident_reg;
    logic [3:0] ident;
    logic [4:0] trig_level;
    logic [1:0] tx_bytes_seen_r;
    logic irq_nxt;
    logic rbr_rd, thr_wr, ier_wr, fcr_wr, iir_rd, lsr_rd, msr_rd;
    logic fifo_toggle;
    logic rx_avail;
    logic line_err;
    logic line_flag;
    logic modem_flag;
    logic timeout_flag, timeout_done, timeout_restart, timeout_run;
    logic tx_holding_empty_int, tx_holding_empty_set, tx_holding_empty_wait, tx_holding_empty_delay_done;
    logic tx_empty;
    logic pend_line, pend_rx, pend_timeout, pend_tx_holding_empty, pend_modem;
    logic any_pend;
    logic [TICK_W-1:0] timeout_limit;
    logic [TICK_W-1:0] tx_holding_empty_limit;

    // Bus decode; the divisor latches share address 0 and 1 and live outside.
    assign rbr_rd = i_rd && i_addr == ADDR_RX_BUFFER && !i_divisor_access;
    assign thr_wr = i_wr && i_addr == ADDR_RX_BUFFER && !i_divisor_access;
    assign ier_wr = i_wr && i_addr == ADDR_IRQ_ENABLE && !i_divisor_access;
    assign fcr_wr = i_wr && i_addr == ADDR_FIFO_CONTROL;
    assign iir_rd = i_rd && i_addr == ADDR_IRQ_IDENT;
    assign lsr_rd = i_rd && i_addr == ADDR_LINE_STATUS;
    assign msr_rd = i_rd && i_addr == ADDR_MODEM_STATUS;

    // upper bits zero: the write mask keeps bits 7..4 clear.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_enable_reg_r <= IER_RESET;
        end else if (ier_wr) begin
            irq_enable_reg_r <= i_wdata & IER_WRITE_MASK;
        end
    end

    // Other control bits are only programmed by a write that sets the fifo enable bit.
    assign fifo_toggle = fcr_wr && (i_wdata[FCR_ENABLE_BIT] != o_fifo_enable_bit);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_fifo_enable_bit <= 1'b0;
            o_rx_trigger_sel <= TRIGGER_RESET;
        end else if (fcr_wr) begin
            o_fifo_enable_bit <= i_wdata[FCR_ENABLE_BIT];
            if (i_wdata[FCR_ENABLE_BIT]) begin
                o_rx_trigger_sel <= i_wdata[FCR_TRIGGER_LSB +: 2];
            end
        end
    end

    // trigger table from the two trigger bits.
    always_comb begin
        case (o_rx_trigger_sel)
            2'h0: trig_level = TRIG_LEVEL_0;
            2'h1: trig_level = TRIG_LEVEL_1;
            2'h2: trig_level = TRIG_LEVEL_2;
            default: trig_level = TRIG_LEVEL_3;
        endcase
    end

    // data ready; without fifos a buffer read empties the single holding slot.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rx_data_ready_flag <= 1'b0;
        end else if (i_rx_push) begin
            o_rx_data_ready_flag <= 1'b1;
        end else if (o_fifo_enable_bit ? (i_rx_count == 5'h00) : rbr_rd) begin
            o_rx_data_ready_flag <= 1'b0;
        end
    end

    // level-sensitive data available, withdrawn as soon as the count drops below the trigger level.
    assign rx_avail = o_fifo_enable_bit ? (i_rx_count >= trig_level) : o_rx_data_ready_flag;

    // overrun counts as a line error and clears on the same status read.
    assign line_err = i_overrun_error || i_parity_error || i_framing_error || i_break_indication;

    // line status flag, cleared by a status read.
    irq_sticky_flag u_line_flag (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(line_err),
        .i_clear(lsr_rd),
        .o_flag(line_flag)
    );

    // modem status flag, cleared by a modem status read.
    irq_sticky_flag u_modem_flag (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(i_modem_change),
        .i_clear(msr_rd),
        .o_flag(modem_flag)
    );

    // four character times in baud ticks, so the delay scales with baud rate.
    assign timeout_limit = TICK_W'(i_char_bits) * TICKS_TIMEOUT_PER_BIT;

    // restart on push only while no time-out is pending; a read always restarts.
    // the timer idles in polled mode so no time-out can build up.
    assign timeout_restart = rbr_rd || (i_rx_push && !timeout_flag);
    assign timeout_run = o_fifo_enable_bit && irq_enable_reg_r[IER_RX_DATA_BIT] && (i_rx_count != 5'h00);

    // time-out needs data and four quiet character times.
    irq_tick_timer #(
        .W(TICK_W)
    ) u_timeout_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_restart(timeout_restart || !timeout_run),
        .i_run(timeout_run),
        .i_tick(i_baud16_tick),
        .i_limit(timeout_limit),
        .o_done(timeout_done)
    );

    // a receive read clears the pending time-out.
    irq_sticky_flag u_timeout_flag (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(timeout_done),
        .i_clear(rbr_rd || !o_fifo_enable_bit),
        .o_flag(timeout_flag)
    );

    // bytes seen since the empty flag was last set, saturating at two.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_bytes_seen_r <= 2'h0;
        end else if (tx_holding_empty_set) begin
            tx_bytes_seen_r <= 2'h0;
        end else if (thr_wr && tx_bytes_seen_r != TX_SHORT_BYTES) begin
            tx_bytes_seen_r <= tx_bytes_seen_r + 2'h1;
        end
    end

    // a short burst delays the empty flag by one character less the stop bit.
    assign tx_empty = (i_tx_count == 5'h00);
    assign tx_holding_empty_wait = o_fifo_enable_bit && tx_empty && !o_tx_holding_empty
        && (tx_bytes_seen_r < TX_SHORT_BYTES);
    assign tx_holding_empty_limit = TICK_W'(i_char_bits - 4'h1) * TICKS_PER_BIT;

    irq_tick_timer #(
        .W(TICK_W)
    ) u_tx_holding_empty_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_restart(!tx_holding_empty_wait),
        .i_run(tx_holding_empty_wait),
        .i_tick(i_baud16_tick),
        .i_limit(tx_holding_empty_limit),
        .o_done(tx_holding_empty_delay_done)
    );

    // The empty indicator sets when the holding side drains and clears on a write.
    assign tx_holding_empty_set = tx_empty && !o_tx_holding_empty && !thr_wr && (tx_holding_empty_wait ? tx_holding_empty_delay_done : 1'b1);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_holding_empty <= 1'b1;
        end else if (tx_holding_empty_set) begin
            o_tx_holding_empty <= 1'b1;
        end else if (thr_wr) begin
            o_tx_holding_empty <= 1'b0;
        end
    end

    // transmit interrupt raised on empty, cleared by write or by reading it out.
    // a change of the fifo enable raises it straight away.
    irq_sticky_flag u_tx_holding_empty_int (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(tx_holding_empty_set || fifo_toggle),
        .i_clear(thr_wr || (iir_rd && ident == IDENT_TX_EMPTY)),
        .o_flag(tx_holding_empty_int)
    );

    // each source gated by its enable bit; data available and time-out share bit 0.
    // with enables clear, trigger and time-out never show.
    assign pend_line = irq_enable_reg_r[IER_LINE_STATUS_BIT] && line_flag;
    assign pend_rx = irq_enable_reg_r[IER_RX_DATA_BIT] && rx_avail;
    assign pend_timeout = irq_enable_reg_r[IER_RX_DATA_BIT] && timeout_flag && o_fifo_enable_bit;
    assign pend_tx_holding_empty = irq_enable_reg_r[IER_TX_EMPTY_BIT] && tx_holding_empty_int;
    assign pend_modem = irq_enable_reg_r[IER_MODEM_BIT] && modem_flag;
    assign any_pend = pend_line || pend_rx || pend_timeout || pend_tx_holding_empty || pend_modem;

    // fixed ranking, only the highest source reported.
    // line status ahead of data available.
    // bit 3 set only for a fifo time-out.
    // pending bit low, code in bits 1-2.
    always_comb begin
        if (pend_line) begin
            ident = IDENT_LINE_STATUS;
        end else if (pend_rx) begin
            ident = IDENT_RX_DATA;
        end else if (pend_timeout) begin
            ident = IDENT_TIMEOUT;
        end else if (pend_tx_holding_empty) begin
            ident = IDENT_TX_EMPTY;
        end else if (pend_modem) begin
            ident = IDENT_MODEM;
        end else begin
            ident = IDENT_NONE;
        end
    end

    // bits 4-5 zero, bits 6-7 mirror the fifo enable.
    assign irq_ident_reg = {o_fifo_enable_bit, o_fifo_enable_bit, 2'h0, ident};

    // Read data is registered, so it appears one cycle after the read strobe.
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            case (i_addr)
                ADDR_IRQ_ENABLE: rdata_nxt = i_divisor_access ? 8'h00 : irq_enable_reg_r;
                ADDR_IRQ_IDENT: rdata_nxt = irq_ident_reg;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_nxt;
        end
    end

    // interrupt output high while any enabled source is pending.
    // with all enables off nothing is pending, so the output stays low.
    assign irq_nxt = any_pend;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_channel_irq_out <= 1'b0;
        end else begin
            o_channel_irq_out <= irq_nxt;
        end
    end

    // Checks, placed beside the logic they watch.
    sequence fifo_change_s;
        fifo_toggle && !thr_wr;
    endsequence

    sequence tx_raised_s;
        ##1 tx_holding_empty_int;
    endsequence

    enable_upper_zero_a:
        assert property (@(posedge i_clk) disable iff (i_reset) irq_enable_reg_r[7:4] == 4'h0)
        else $error("Upper enable bits not zero.");

    irq_follows_a:
        assert property (@(posedge i_clk) disable iff (i_reset) any_pend |=> o_channel_irq_out)
        else $error("Interrupt output missing while pending.");

    no_enable_quiet_a:
        assert property (@(posedge i_clk) disable iff (i_reset)
            irq_enable_reg_r[3:0] == 4'h0 |=> !o_channel_irq_out || $past(ier_wr))
        else $error("Interrupt output with all enables clear.");

    ident_bit0_a:
        assert property (@(posedge i_clk) disable iff (i_reset)
            iir_rd |=> o_rdata[0] == !$past(any_pend))
        else $error("Pending bit does not match pending state.");

    line_first_a:
        assert property (@(posedge i_clk) disable iff (i_reset)
            iir_rd && pend_line |=> o_rdata[3:0] == IDENT_LINE_STATUS)
        else $error("Line status not reported first.");

    ident_top_a:
        assert property (@(posedge i_clk) disable iff (i_reset)
            iir_rd |=> o_rdata[7:4] == {$past(o_fifo_enable_bit), $past(o_fifo_enable_bit), 2'h0})
        else $error("Identification upper bits wrong.");

    timeout_bit3_a:
        assert property (@(posedge i_clk) disable iff (i_reset) !o_fifo_enable_bit |-> !irq_ident_reg[3])
        else $error("Time-out bit set without fifos.");

    timeout_clear_a:
        assert property (@(posedge i_clk) disable iff (i_reset) rbr_rd |=> !timeout_flag)
        else $error("Receive read did not clear time-out.");

    polled_quiet_a:
        assert property (@(posedge i_clk) disable iff (i_reset)
            iir_rd && o_fifo_enable_bit && irq_enable_reg_r[3:0] == 4'h0 |=> o_rdata[3:0] == IDENT_NONE)
        else $error("Trigger or time-out shown in polled mode.");

    line_read_a:
        assert property (@(posedge i_clk) disable iff (i_reset) lsr_rd && !line_err |=> !line_flag)
        else $error("Status read did not clear line flag.");

    fifo_change_a:
        assert property (@(posedge i_clk) disable iff (i_reset) fifo_change_s |-> tx_raised_s)
        else $error("No transmit interrupt after fifo change.");

    rx_ready_a:
        assert property (@(posedge i_clk) disable iff (i_reset) i_rx_push |=> o_rx_data_ready_flag)
        else $error("Data ready not set on push.");

endmodule // uart_irq_ctrl
`default_nettype wire

// *** sim/serial_engine_model.sv ***
// Model of the channel's serial engine as the interrupt logic sees it.
// Assumes bench requests arrive as one-cycle pulses on i_clk.
`timescale 1ns/1ps
`default_nettype none
module serial_engine_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_tx_wr,
    input wire logic i_tx_drain,
    output logic o_baud16_tick,
    output logic o_rx_push,
    output logic [4:0] o_rx_count,
    output logic [4:0] o_tx_count
);
    logic tick_r;

    // A tick every other cycle keeps character times short but nonzero.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= ~tick_r;
        end
    end
    assign o_baud16_tick = tick_r;
    assign o_rx_push = i_push;

    // Fill counts follow pushes, host reads and host writes; both stop at sixteen.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rx_count <= 5'h00;
            o_tx_count <= 5'h00;
        end else begin
            o_rx_count <= o_rx_count + 5'(i_push && o_rx_count < 5'h10) - 5'(i_pop && o_rx_count != 5'h00);
            o_tx_count <= o_tx_count + 5'(i_tx_wr && o_tx_count < 5'h10) - 5'(i_tx_drain && o_tx_count != 5'h00);
        end
    end
endmodule // serial_engine_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the serial channel interrupt logic.
// Assumes the engine model supplies ticks and fill counts; the bench plays the host.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uart_irq_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] addr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic div_acc = 1'b0;
    logic [3:0] char_bits = 4'h2;
    logic [3:0] err = 4'h0;
    logic modem = 1'b0;
    logic push = 1'b0;
    logic drain = 1'b0;
    logic tick;
    logic rx_push;
    logic [4:0] rx_count;
    logic [4:0] tx_count;
    logic [7:0] rdata;
    logic irq;
    logic dr;
    logic tx_holding_empty;
    logic fen;
    logic [1:0] tsel;
    logic [7:0] got;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    integer seed = 32'h8D911BF8;

    always #2.5 i_clk = ~i_clk;

    uart_irq_ctrl uart_irq_ctrl_inst (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr), .i_rd(rd), .i_wr(wr),
        .i_wdata(wdata), .i_divisor_access(div_acc), .i_baud16_tick(tick), .i_char_bits(char_bits),
        .i_rx_push(rx_push), .i_rx_count(rx_count), .i_tx_count(tx_count), .i_overrun_error(err[0]),
        .i_parity_error(err[1]), .i_framing_error(err[2]), .i_break_indication(err[3]),
        .i_modem_change(modem), .o_rdata(rdata), .o_channel_irq_out(irq), .o_rx_data_ready_flag(dr),
        .o_tx_holding_empty(tx_holding_empty), .o_fifo_enable_bit(fen), .o_rx_trigger_sel(tsel));

    serial_engine_model serial_engine_model_inst (.i_clk(i_clk), .i_reset(i_reset), .i_push(push),
        .i_pop(rd && addr == ADDR_RX_BUFFER && !div_acc), .i_tx_wr(wr && addr == ADDR_RX_BUFFER && !div_acc),
        .i_tx_drain(drain), .o_baud16_tick(tick), .o_rx_push(rx_push), .o_rx_count(rx_count),
        .o_tx_count(tx_count));

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask

    // One register access; read data is taken the cycle after the read edge.
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
        step(1);
        rd = ~w;
        wr = w;
        addr = a;
        wdata = d;
        step(1);
        rd = 1'b0;
        wr = 1'b0;
        got = rdata;
    endtask

    task automatic expect_rd(input logic [2:0] a, input logic [7:0] e);
        access(1'b0, a, 8'h00);
        check(got, e);
    endtask

    task automatic pulse_events(input logic [3:0] e, input logic m, input logic p);
        err = e;
        modem = m;
        push = p;
        step(1);
        err = 4'h0;
        modem = 1'b0;
        push = 1'b0;
    endtask

    // Receive trigger level in bytes for each selector value.
    function automatic int level(input int t);
        return (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
    endfunction

    // A hang is cut short after a generous cycle budget.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        step(6);
        i_reset = 1'b0;
        check({7'h0, irq}, 8'h00);
        check({7'h0, tx_holding_empty}, 8'h01);
        expect_rd(ADDR_IRQ_IDENT, 8'h01);
        access(1'b1, ADDR_IRQ_ENABLE, 8'hF0);
        expect_rd(ADDR_IRQ_ENABLE, 8'h00);
        // With the divisor latches mapped, the enable register is neither written nor read.
        div_acc = 1'b1;
        access(1'b1, ADDR_IRQ_ENABLE, 8'h0F);
        expect_rd(ADDR_IRQ_ENABLE, 8'h00);
        div_acc = 1'b0;
        expect_rd(ADDR_IRQ_ENABLE, 8'h00);
        expect_rd(3'h7, 8'h00);
        // Line errors and modem changes: gated while disabled, ranked once enabled.
        for (int i = 0; i < 4; i++) begin
            access(1'b1, ADDR_IRQ_ENABLE, 8'h00);
            pulse_events(4'h1 << i, 1'b1, 1'b0);
            step(3);
            check({7'h0, irq}, 8'h00);
            expect_rd(ADDR_IRQ_IDENT, 8'h01);
            access(1'b1, ADDR_IRQ_ENABLE, 8'h0C);
            step(3);
            check({7'h0, irq}, 8'h01);
            expect_rd(ADDR_IRQ_IDENT, 8'h06);
            access(1'b0, ADDR_LINE_STATUS, 8'h00);
            step(3);
            expect_rd(ADDR_IRQ_IDENT, 8'h00);
            access(1'b0, ADDR_MODEM_STATUS, 8'h00);
            step(3);
            expect_rd(ADDR_IRQ_IDENT, 8'h01);
            check({7'h0, irq}, 8'h00);
        end
        // Each trigger level: below, at, and back below the programmed count.
        for (int t = 0; t < 4; t++) begin
            access(1'b1, ADDR_FIFO_CONTROL, {2'(t), 6'h01});
            access(1'b1, ADDR_IRQ_ENABLE, 8'h01);
            check({6'h0, tsel}, 8'(t));
            for (int k = 1; k < level(t); k++) pulse_events(4'h0, 1'b0, 1'b1);
            step(2);
            expect_rd(ADDR_IRQ_IDENT, 8'hC1);
            pulse_events(4'h0, 1'b0, 1'b1);
            step(3);
            expect_rd(ADDR_IRQ_IDENT, 8'hC4);
            check({7'h0, dr}, 8'h01);
            access(1'b0, ADDR_RX_BUFFER, 8'h00);
            step(3);
            expect_rd(ADDR_IRQ_IDENT, 8'hC1);
            while (rx_count != 5'h00) access(1'b0, ADDR_RX_BUFFER, 8'h00);
            step(3);
            check({7'h0, dr}, 8'h00);
        end
        // Polled mode: data is held but no condition is signalled.
        access(1'b1, ADDR_IRQ_ENABLE, 8'h00);
        n = 1 + ($unsigned($random(seed)) % 3);
        repeat (n) pulse_events(4'h0, 1'b0, 1'b1);
        step(400);
        check({7'h0, irq}, 8'h00);
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        check({7'h0, dr}, 8'h01);
        // Time-out: four character times of 32 ticks, restarted by a push.
        access(1'b1, ADDR_IRQ_ENABLE, 8'h01);
        step(200);
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        pulse_events(4'h0, 1'b0, 1'b1);
        step(200);
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        step(100);
        expect_rd(ADDR_IRQ_IDENT, 8'hCC);
        check({7'h0, irq}, 8'h01);
        // Longer characters stretch the time-out; a buffer read clears it.
        char_bits = 4'h4;
        access(1'b0, ADDR_RX_BUFFER, 8'h00);
        step(3);
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        step(400);
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        step(150);
        expect_rd(ADDR_IRQ_IDENT, 8'hCC);
        while (rx_count != 5'h00) access(1'b0, ADDR_RX_BUFFER, 8'h00);
        // Fifos off: top bits and the time-out bit read zero.
        access(1'b1, ADDR_IRQ_ENABLE, 8'h00);
        access(1'b1, ADDR_FIFO_CONTROL, 8'h00);
        check({7'h0, fen}, 8'h00);
        check({6'h0, tsel}, 8'h03);
        expect_rd(ADDR_IRQ_IDENT, 8'h01);
        // Transmit empty: raised on enable change, cleared by ident read and by a write.
        access(1'b1, ADDR_IRQ_ENABLE, 8'h02);
        expect_rd(ADDR_IRQ_IDENT, 8'h02);
        access(1'b1, ADDR_FIFO_CONTROL, 8'h01);
        step(3);
        expect_rd(ADDR_IRQ_IDENT, 8'hC2);
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        access(1'b1, ADDR_RX_BUFFER, 8'($random(seed)));
        step(2);
        check({7'h0, tx_holding_empty}, 8'h00);
        drain = 1'b1;
        step(1);
        drain = 1'b0;
        step(20);
        check({7'h0, tx_holding_empty}, 8'h00);
        step(100);
        check({7'h0, tx_holding_empty}, 8'h01);
        expect_rd(ADDR_IRQ_IDENT, 8'hC2);
        for (int k = 0; k < 16; k++) access(1'b1, ADDR_RX_BUFFER, 8'($random(seed)));
        expect_rd(ADDR_IRQ_IDENT, 8'hC1);
        drain = 1'b1;
        step(16);
        drain = 1'b0;
        step(4);
        check({7'h0, tx_holding_empty}, 8'h01);
        end_sim();
    end
endmodule // tb
`default_nettype wire
